// File: reset_sequence_init.sv
`timescale 1ns/10ps
`default_nettype none
`include "reset_sequence_init_defines.svh"

module reset_sequence_init #(
    parameter int STALL_CYC = `RSI_STALL_TYP_CYC,
    parameter int SETTLE_CYC = `RSI_SETTLE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_reset_pin_n,
    input wire logic i_wdt_overflow,
    input wire logic [15:0] i_vector,
    input wire logic i_from_standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic o_cpu_run,
    output logic o_apply_init,
    output logic o_wdt_restart,
    output logic o_retain_ram,
    output logic [15:0] o_program_counter,
    output logic o_reset_indicator_pin,
    output logic o_reset_indicator_oe,
    output logic o_pins_hiz,
    output reset_sequence_init_pkg::init_values_t o_init
);

    // pin synchroniser stages
    logic pin_meta_reg;
    logic pin_sync_reg;
    // sequencer state and timer
    reset_sequence_init_pkg::seq_state_t state_reg;
    reset_sequence_init_pkg::seq_state_t state_next;
    logic [31:0] cnt_reg;
    // software controls
    logic ind_high_reg;
    logic xtal_sel_reg;
    // vector capture
    logic [15:0] pc_reg;
    // reset request this cycle
    logic req;
    logic apb_wr;
    logic apb_rd;

    // two-flop sync; nothing reads the first stage except the second
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= i_reset_pin_n;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // request sources
    // pin low or watchdog overflow; pin must be held by the source
    assign req = ~pin_sync_reg | i_wdt_overflow;

    // phase sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            reset_sequence_init_pkg::ST_HOLD: begin
                if (!req) begin
                    state_next = reset_sequence_init_pkg::ST_STALL;
                end
            end
            reset_sequence_init_pkg::ST_STALL: begin
                if (cnt_reg >= 32'(STALL_CYC - 1)) begin
                    state_next = xtal_sel_reg ? reset_sequence_init_pkg::ST_SETTLE
                                              : reset_sequence_init_pkg::ST_RUN;
                end
            end
            reset_sequence_init_pkg::ST_SETTLE: begin
                if (cnt_reg >= 32'(SETTLE_CYC - 1)) begin
                    state_next = reset_sequence_init_pkg::ST_RUN;
                end
            end
            reset_sequence_init_pkg::ST_RUN: begin
                state_next = reset_sequence_init_pkg::ST_RUN;
            end
            default: begin
                state_next = reset_sequence_init_pkg::ST_HOLD;
            end
        endcase
        // a new request always wins
        if (req) begin
            state_next = reset_sequence_init_pkg::ST_HOLD;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= reset_sequence_init_pkg::ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // interval counter restart
    // counter clears on any request and on each phase change
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 32'h0000_0000;
        end else if (req || state_next != state_reg) begin
            cnt_reg <= 32'h0000_0000;
        end else if (state_reg != reset_sequence_init_pkg::ST_RUN) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

    // vector load
    // taken as the last wait phase (stall, or settle when selected) ends so the fetch sees a stable vector
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_reg <= `RSI_WORD_ZERO;
        end else if (state_reg != reset_sequence_init_pkg::ST_RUN
                     && state_next == reset_sequence_init_pkg::ST_RUN) begin
            pc_reg <= i_vector;
        end
    end

    // indicator control
    // request forces low; only a software write raises it again
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ind_high_reg <= 1'b0;
        end else if (req) begin
            ind_high_reg <= 1'b0;
        end else if (apb_wr && paddr == `RSI_OFS_CTRL) begin
            ind_high_reg <= pwdata[`RSI_CTRL_IND_BIT];
        end
    end

    // clock source select survives reset requests, like an option setting
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            xtal_sel_reg <= 1'b0;
        end else if (apb_wr && paddr == `RSI_OFS_CTRL) begin
            xtal_sel_reg <= pwdata[`RSI_CTRL_XTAL_BIT];
        end
    end

    // sequencer outputs, all registered
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cpu_run <= 1'b0;
            o_apply_init <= 1'b0;
            o_wdt_restart <= 1'b0;
            o_retain_ram <= 1'b0;
            o_pins_hiz <= 1'b1;
            o_reset_indicator_pin <= 1'b0;
            o_reset_indicator_oe <= 1'b1;
            o_program_counter <= `RSI_WORD_ZERO;
        end else begin
            o_cpu_run <= (state_next == reset_sequence_init_pkg::ST_RUN);
            o_apply_init <= (state_reg != reset_sequence_init_pkg::ST_RUN
                             && state_next == reset_sequence_init_pkg::ST_RUN);
            o_wdt_restart <= i_wdt_overflow;
            if (req) begin
                o_retain_ram <= i_from_standby;
            end
            o_pins_hiz <= (state_next != reset_sequence_init_pkg::ST_RUN);
            o_reset_indicator_pin <= ind_high_reg & ~req;
            o_reset_indicator_oe <= 1'b1;
            // vector with the run edge
            // the cpu must never start on a stale address, so the vector bypasses pc_reg here
            if (state_reg != reset_sequence_init_pkg::ST_RUN
                && state_next == reset_sequence_init_pkg::ST_RUN) begin
                o_program_counter <= i_vector;
            end else begin
                o_program_counter <= pc_reg;
            end
        end
    end

    // constant set
    // settle select, interval compare and converter result are left out on purpose
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_init <= '0;
        end else begin
            o_init.processor_status_word <= `RSI_PSW_RST;
            o_init.port_latch <= `RSI_PORT_LATCH_RST;
            o_init.port_dir <= `RSI_PORT_DIR_RST;
            o_init.pullup_sel <= `RSI_PULLUP_RST;
            o_init.port_altfunc_ctrl <= `RSI_ALTFUNC_RST;
            o_init.cpu_clock_ctrl <= `RSI_CLK_CTRL_RST;
            o_init.prescaler_clock_ctrl <= `RSI_CLK_CTRL_RST;
            o_init.wide_timer_count <= `RSI_WORD_ZERO;
            o_init.wide_capcmp_a <= `RSI_WORD_ZERO;
            o_init.wide_capcmp_b <= `RSI_WORD_ZERO;
            o_init.wide_timer_mode <= `RSI_BYTE_ZERO;
            o_init.wide_timer_prescale <= `RSI_BYTE_ZERO;
            o_init.wide_capcmp_ctrl <= `RSI_BYTE_ZERO;
            o_init.wide_timer_out_ctrl <= `RSI_BYTE_ZERO;
            o_init.interval_timer_count <= `RSI_BYTE_ZERO;
            o_init.interval_timer_mode <= `RSI_BYTE_ZERO;
            o_init.pulse_timer_compare_a <= `RSI_BYTE_ZERO;
            o_init.pulse_timer_compare_b <= `RSI_BYTE_ZERO;
            o_init.pulse_timer_mode <= `RSI_BYTE_ZERO;
            o_init.conv_mode <= `RSI_BYTE_ZERO;
            o_init.conv_channel_select <= `RSI_BYTE_ZERO;
        end
    end

    // apb strobes; zero-wait answer in the access cycle
    assign apb_wr = psel & penable & pwrite & pready;
    // setup cycle of any transfer: the answer is decoded one cycle ahead
    assign apb_rd = psel & ~penable;

    // apb ready and read data, registered in the setup cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_rd;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (apb_rd) begin
                unique case (paddr)
                    `RSI_OFS_CTRL: begin
                        prdata <= {30'h0, xtal_sel_reg, ind_high_reg};
                    end
                    `RSI_OFS_STATUS: begin
                        prdata <= {28'h000_0000, state_reg};
                    end
                    `RSI_OFS_VECTOR: begin
                        prdata <= {16'h0000, pc_reg};
                    end
                    `RSI_OFS_PSW: begin
                        prdata <= 32'h0000_0000 | `RSI_PSW_RST;
                    end
                    default: begin
                        // unmapped: error answer
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // stall must keep the cpu held for 8 cycles before run
    property p_stall_len;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(state_reg == reset_sequence_init_pkg::ST_STALL) && !req
        |-> !o_cpu_run [*8];
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("run during stall");

    property p_xtal_settle;
        @(posedge i_sys_clk) disable iff (i_rst)
        state_reg == reset_sequence_init_pkg::ST_STALL && xtal_sel_reg && !req
        && state_next != reset_sequence_init_pkg::ST_STALL
        |=> state_reg == reset_sequence_init_pkg::ST_SETTLE;
    endproperty
    a_xtal_settle: assert property (p_xtal_settle) else $error("settle skipped");

    property p_ind_low;
        @(posedge i_sys_clk) disable iff (i_rst)
        req |=> !o_reset_indicator_pin && o_reset_indicator_oe;
    endproperty
    a_ind_low: assert property (p_ind_low) else $error("indicator not low");

    property p_hold_on_req;
        @(posedge i_sys_clk) disable iff (i_rst)
        req |=> state_reg == reset_sequence_init_pkg::ST_HOLD && !o_cpu_run;
    endproperty
    a_hold_on_req: assert property (p_hold_on_req) else $error("request not held");

    property p_wdt_restart;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_wdt_overflow |=> o_wdt_restart;
    endproperty
    a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog not restarted");

    property p_counter_restart;
        @(posedge i_sys_clk) disable iff (i_rst)
        req |=> cnt_reg == 32'h0000_0000;
    endproperty
    a_counter_restart: assert property (p_counter_restart) else $error("counter not restarted");

    property p_vector;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(o_apply_init) |-> o_program_counter == $past(i_vector);
    endproperty
    a_vector: assert property (p_vector) else $error("vector not loaded");

    property p_init_vals;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_apply_init |-> o_init.processor_status_word == `RSI_PSW_RST
        && o_init.port_dir == `RSI_PORT_DIR_RST && o_init.cpu_clock_ctrl == `RSI_CLK_CTRL_RST;
    endproperty
    a_init_vals: assert property (p_init_vals) else $error("bad reset value");

    property p_apply_once;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_apply_init |=> !o_apply_init;
    endproperty
    a_apply_once: assert property (p_apply_once) else $error("init applied twice");

    c_run: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(o_cpu_run));
    c_settle: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == reset_sequence_init_pkg::ST_SETTLE);
    c_wdt: cover property (@(posedge i_sys_clk) disable iff (i_rst) i_wdt_overflow ##1 !req);
    // a request landing in mid-stall
    c_restart: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        state_reg == reset_sequence_init_pkg::ST_STALL && req);

endmodule // reset_sequence_init
`default_nettype wire

// File: reset_sequence_init_defines.svh
`ifndef RESET_SEQUENCE_INIT_DEFINES_SVH
`define RESET_SEQUENCE_INIT_DEFINES_SVH

// clock rate in kHz
`define RSI_CLK_KHZ 20000
// external reset minimum low time, microseconds
`define RSI_EXT_LOW_MIN_US 2
`define RSI_EXT_LOW_MIN_CYC ((`RSI_EXT_LOW_MIN_US * `RSI_CLK_KHZ + 999) / 1000)
// configuration stall, typical figure in microseconds
`define RSI_STALL_TYP_US 544
`define RSI_STALL_TYP_CYC ((`RSI_STALL_TYP_US * `RSI_CLK_KHZ) / 1000)
// crystal settle wait default in cycles
`define RSI_SETTLE_CYC 16384

// reset values
`define RSI_PSW_RST 8'h02
`define RSI_PORT_LATCH_RST 8'h00
`define RSI_PORT_DIR_RST 8'hff
`define RSI_PULLUP_RST 8'h00
`define RSI_ALTFUNC_RST 8'h00
`define RSI_CLK_CTRL_RST 8'h02
`define RSI_BYTE_ZERO 8'h00
`define RSI_WORD_ZERO 16'h0000

// register offsets, chosen
`define RSI_OFS_CTRL 12'h000
`define RSI_OFS_STATUS 12'h004
`define RSI_OFS_VECTOR 12'h008
`define RSI_OFS_PSW 12'h00c

// control register fields
`define RSI_CTRL_IND_BIT 0
`define RSI_CTRL_XTAL_BIT 1

`endif

// File: reset_sequence_init_pkg.sv
package reset_sequence_init_pkg;

    // reset sequence phases, one-hot
    typedef enum logic [3:0] {
        ST_HOLD = 4'b0001,
        ST_STALL = 4'b0010,
        ST_SETTLE = 4'b0100,
        ST_RUN = 4'b1000
    } seq_state_t;

    // forced values for the peripheral registers
    typedef struct packed {
        logic [7:0] processor_status_word;
        logic [7:0] port_latch;
        logic [7:0] port_dir;
        logic [7:0] pullup_sel;
        logic [7:0] port_altfunc_ctrl;
        logic [7:0] cpu_clock_ctrl;
        logic [7:0] prescaler_clock_ctrl;
        logic [15:0] wide_timer_count;
        logic [15:0] wide_capcmp_a;
        logic [15:0] wide_capcmp_b;
        logic [7:0] wide_timer_mode;
        logic [7:0] wide_timer_prescale;
        logic [7:0] wide_capcmp_ctrl;
        logic [7:0] wide_timer_out_ctrl;
        logic [7:0] interval_timer_count;
        logic [7:0] interval_timer_mode;
        logic [7:0] pulse_timer_compare_a;
        logic [7:0] pulse_timer_compare_b;
        logic [7:0] pulse_timer_mode;
        logic [7:0] conv_mode;
        logic [7:0] conv_channel_select;
    } init_values_t;

endpackage

// File: reset_source_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "reset_sequence_init_defines.svh"

// far side: external reset pin driver and watchdog overflow source
module reset_source_model (
    input wire logic i_sys_clk,
    input wire logic i_go,
    input wire logic i_use_wdt,
    input wire logic [15:0] i_hold,
    output logic o_reset_pin_n,
    output logic o_wdt_overflow
);
    logic [15:0] left_reg = 16'h0000; // request cycles still to run
    logic wdt_reg = 1'b0; // source of the running request

    // pin low long enough
    // a short pin request is stretched, so the bench cannot break the minimum by accident
    always @(posedge i_sys_clk) begin
        if (i_go) begin
            left_reg <= (!i_use_wdt && i_hold < `RSI_EXT_LOW_MIN_CYC) ? 16'(`RSI_EXT_LOW_MIN_CYC) : i_hold;
            wdt_reg <= i_use_wdt;
        end else if (left_reg != 16'h0000) begin
            left_reg <= left_reg - 16'h0001;
        end
    end

    assign o_wdt_overflow = wdt_reg && (left_reg != 16'h0000);
    // pin idles high between requests
    assign o_reset_pin_n = !(!wdt_reg && (left_reg != 16'h0000));
endmodule // reset_source_model
`default_nettype wire

// File: reset_sequence_init_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "reset_sequence_init_defines.svh"

module reset_sequence_init_test;
    localparam int STALL = 8; // shortened stall
    localparam int SETTLE = 4; // shortened settle
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0; // starts a far-side request
    logic use_wdt = 1'b0;
    logic [15:0] hold = 16'h0000;
    logic reset_pin_n, wdt_overflow;
    logic [15:0] i_vector = 16'h1234;
    logic i_from_standby = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, o_cpu_run, o_apply_init, o_wdt_restart, o_retain_ram;
    logic [15:0] o_program_counter;
    logic o_reset_indicator_pin, o_reset_indicator_oe, o_pins_hiz;
    reset_sequence_init_pkg::init_values_t o_init;
    int errors = 0;
    int comparisons = 0;

    // 20 MHz
    always #25 i_sys_clk = ~i_sys_clk;

    reset_sequence_init #(.STALL_CYC(STALL), .SETTLE_CYC(SETTLE)) uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_reset_pin_n(reset_pin_n), .i_wdt_overflow(wdt_overflow), .i_vector(i_vector),
        .i_from_standby(i_from_standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_cpu_run(o_cpu_run),
        .o_apply_init(o_apply_init), .o_wdt_restart(o_wdt_restart), .o_retain_ram(o_retain_ram),
        .o_program_counter(o_program_counter), .o_reset_indicator_pin(o_reset_indicator_pin),
        .o_reset_indicator_oe(o_reset_indicator_oe), .o_pins_hiz(o_pins_hiz), .o_init(o_init));

    reset_source_model far_side (.i_sys_clk(i_sys_clk), .i_go(go), .i_use_wdt(use_wdt), .i_hold(hold),
        .o_reset_pin_n(reset_pin_n), .o_wdt_overflow(wdt_overflow));

    // verdict and stop, also reached from a timeout
    task automatic end_sim;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // forced values worked out independently of the design
    task automatic chk_init(input reset_sequence_init_pkg::init_values_t got);
        reset_sequence_init_pkg::init_values_t exp;
        exp = '0;
        exp.processor_status_word = 8'h02;
        exp.port_dir = 8'hff;
        exp.cpu_clock_ctrl = 8'h02;
        exp.prescaler_clock_ctrl = 8'h02;
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] init values expected %h seen %h", exp, got);
        end
    endtask

    // one apb transfer; idle edge first so a new setup never lands on a release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic request(input logic wdt, input logic [15:0] h);
        @(posedge i_sys_clk);
        use_wdt <= wdt;
        hold <= h;
        go <= 1'b1;
        @(posedge i_sys_clk);
        go <= 1'b0;
    endtask

    // edges from request release until the cpu runs
    task automatic run_count(input logic wait_drop, output int n);
        int k;
        for (k = 0; wait_drop && k < 200; k++) begin
            @(posedge i_sys_clk);
            if (reset_pin_n === 1'b1 && wdt_overflow === 1'b0) break;
        end
        for (n = 0; n < 2000; n++) begin
            @(posedge i_sys_clk);
            if (o_cpu_run === 1'b1) break;
        end
        if (k == 200 || n == 2000) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic t_power_up;
        int n;
        chk("pins hiz", 32'h1, o_pins_hiz);
        chk("indicator", 32'h0, o_reset_indicator_pin);
        chk("indicator oe", 32'h1, o_reset_indicator_oe);
        i_rst <= 1'b0;
        run_count(1'b0, n);
        chk("apply pulse", 32'h1, o_apply_init);
        @(posedge i_sys_clk);
        chk("apply width", 32'h0, o_apply_init);
        chk("pc", 32'h1234, o_program_counter);
        chk_init(o_init);
        chk("pins driven", 32'h0, o_pins_hiz);
        chk("indicator", 32'h0, o_reset_indicator_pin);
    endtask

    task automatic t_regs;
        apb(1'b0, `RSI_OFS_PSW, 32'h0000_0000);
        chk("psw", 32'h02, rd);
        chk("psw err", 32'h0, er);
        apb(1'b0, `RSI_OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h8, rd);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk("unmapped err", 32'h1, er);
        apb(1'b1, `RSI_OFS_VECTOR, 32'h0000_5555);
        apb(1'b0, `RSI_OFS_VECTOR, 32'h0000_0000);
        chk("vector", 32'h1234, rd);
        apb(1'b1, `RSI_OFS_CTRL, 32'h0000_0001);
        // control bit is set at the access edge; one edge for the registered pin, one more before it can be read
        repeat (2) @(posedge i_sys_clk);
        chk("indicator", 32'h1, o_reset_indicator_pin);
    endtask

    // pin reset, with or without the crystal settle wait
    task automatic t_pin(input logic xtal);
        int n;
        int lo;
        apb(1'b1, `RSI_OFS_CTRL, {30'h0, xtal, 1'b1});
        i_vector <= xtal ? 16'h4321 : 16'h0abc;
        request(1'b0, 16'h0004);
        repeat (6) @(posedge i_sys_clk);
        chk("cpu held", 32'h0, o_cpu_run);
        chk("indicator", 32'h0, o_reset_indicator_pin);
        chk("pins hiz", 32'h1, o_pins_hiz);
        run_count(1'b1, n);
        lo = STALL + 1 + (xtal ? SETTLE : 0);
        chk("stall", 32'h1, 32'(n >= lo && n <= lo + 3));
        @(posedge i_sys_clk);
        chk("pc", 32'(i_vector), o_program_counter);
    endtask

    task automatic t_wdt;
        int n;
        apb(1'b1, `RSI_OFS_CTRL, 32'h0000_0001);
        i_from_standby <= 1'b1;
        request(1'b1, 16'h0003);
        repeat (2) @(posedge i_sys_clk);
        chk("wdt restart", 32'h1, o_wdt_restart);
        run_count(1'b1, n);
        // overflow needs no synchroniser, so the count starts two edges earlier than for the pin
        chk("stall", 32'h1, 32'(n >= STALL && n <= STALL + 3));
        chk("retain", 32'h1, o_retain_ram);
        chk("indicator", 32'h0, o_reset_indicator_pin);
        i_from_standby <= 1'b0;
    endtask

    // second request in mid-stall must start the count again
    task automatic t_restart;
        int n;
        request(1'b1, 16'h0002);
        repeat (6) @(posedge i_sys_clk);
        request(1'b1, 16'h0002);
        run_count(1'b1, n);
        chk("restart", 32'h1, 32'(n >= STALL && n <= STALL + 3));
        chk("wdt restart", 32'h0, o_wdt_restart);
        chk("retain", 32'h0, o_retain_ram);
    endtask

    initial begin
        repeat (20) @(posedge i_sys_clk);
        t_power_up();
        t_regs();
        t_pin(1'b0);
        t_pin(1'b1);
        t_wdt();
        t_restart();
        end_sim();
    end
endmodule // reset_sequence_init_test
`default_nettype wire
